// ---- autosave_scheduler.sv ----
`timescale 1ns/1ns
`default_nettype none
module autosave_scheduler
    import drive_params_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic minute_tick_in,
    input wire logic enable_in,
    input wire logic [15:0] interval_code_in,
    output logic store_out
);

    logic [6:0] minutes_reg;
    logic [15:0] code_prev_reg;
    logic [6:0] period;

    assign period = autosave_minutes(interval_code_in);

    // (R13) Periodic store
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            minutes_reg <= 7'h00;
            code_prev_reg <= AUTOSAVE_RESET;
            store_out <= 1'b0;
        end else if (ce_in) begin
            code_prev_reg <= interval_code_in;
            store_out <= 1'b0;
            if (!enable_in || period == 7'h00 || code_prev_reg != interval_code_in) begin
                minutes_reg <= 7'h00;
            end else if (minute_tick_in) begin
                if (minutes_reg + 7'h01 >= period) begin
                    minutes_reg <= 7'h00;
                    store_out <= 1'b1;
                end else begin
                    minutes_reg <= minutes_reg + 7'h01;
                end
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_store_needs_enable: assert property (store_out // (R13)
        |-> $past(enable_in) && $past(period) != 7'h00)
        else $error("autosave store while disabled");
    a_interval_decode: assert property (interval_code_in == 16'h0003 // (R12)
        |-> period == 7'h0F)
        else $error("autosave interval decode wrong");

endmodule
`default_nettype wire

// ---- drive_params_pkg.sv ----
package drive_params_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter addresses
    localparam logic [15:0] ADDR_ENCODER_PRESET = 16'h052C;
    localparam logic [15:0] ADDR_ERROR_BEHAVIOUR = 16'h190C;
    localparam logic [15:0] ADDR_REPLACEMENT_ENABLE = 16'h1A28;
    localparam logic [15:0] ADDR_AUTOSAVE_INTERVAL = 16'h1A2A;
    localparam logic [15:0] ADDR_STATUS_WORD = 16'h1B04;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
    localparam logic [15:0] ERROR_BEHAVIOUR_RESET = 16'h0000;
    localparam logic [15:0] REPLACEMENT_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] AUTOSAVE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Status word bit positions
    localparam int STAT_VOLTAGE_BIT = 4;
    localparam int STAT_WARNING_BIT = 7;
    localparam int STAT_HALT_BIT = 8;
    localparam int STAT_REMOTE_BIT = 9;
    localparam int STAT_TARGET_BIT = 10;
    localparam int STAT_RESERVED_BIT = 11;
    localparam int STAT_MODE_SPEC_BIT = 12;
    localparam int STAT_MODE_ERR_BIT = 13;
    localparam int STAT_MOTION_END_BIT = 14;
    localparam int STAT_REF_OK_BIT = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Selector codes and limits
    localparam logic [15:0] BEHAVIOUR_WARNING = 16'h0000;
    localparam logic [15:0] BEHAVIOUR_QUICK_STOP = 16'h0001;
    localparam logic [15:0] REPLACEMENT_ON = 16'h0001;
    localparam logic [15:0] AUTOSAVE_MAX_CODE = 16'h0005;
    localparam int MULTITURN_FACTOR = 4096;
    localparam int MAX_POS_PER_REV_DEFAULT = 16384;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint CLK_HZ = 50_000_000;
    localparam longint MINUTE_S = 60;
    localparam logic [31:0] MINUTE_CYCLES_DEFAULT = 32'(MINUTE_S * CLK_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [5:0] state_code;
        logic voltage_enabled;
        logic warning;
        logic halt_active;
        logic remote;
        logic target_reached;
        logic mode_specific;
        logic mode_error;
        logic motion_end;
        logic ref_valid;
    } drive_flags_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } param_req_t;

    typedef struct packed {
        logic done;
        logic refused;
        logic [31:0] rdata;
    } param_rsp_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] pack_status(input drive_flags_t f);
        logic [15:0] w;
        w = 16'h0000;
        w[3:0] = f.state_code[3:0];
        w[5] = f.state_code[4];
        w[6] = f.state_code[5];
        w[STAT_VOLTAGE_BIT] = f.voltage_enabled;
        w[STAT_WARNING_BIT] = f.warning;
        w[STAT_HALT_BIT] = f.halt_active;
        w[STAT_REMOTE_BIT] = f.remote;
        w[STAT_TARGET_BIT] = f.target_reached;
        w[STAT_RESERVED_BIT] = 1'b0;
        w[STAT_MODE_SPEC_BIT] = f.mode_specific;
        w[STAT_MODE_ERR_BIT] = f.mode_error;
        w[STAT_MOTION_END_BIT] = f.motion_end;
        w[STAT_REF_OK_BIT] = f.ref_valid;
        return w;
    endfunction

    function automatic logic [6:0] autosave_minutes(input logic [15:0] code);
        case (code)
            16'h0001: return 7'h01;
            16'h0002: return 7'h05;
            16'h0003: return 7'h0F;
            16'h0004: return 7'h1E;
            16'h0005: return 7'h3C;
            default: return 7'h00;
        endcase
    endfunction

endpackage

// ---- drive_status_fieldbus_params.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// (R01) Status bits 0-3,5,6 carry the state, bit 4 voltage, bit 7 warning, bit 8 halt.
// (R02) Status bit 9 is remote, bit 10 target reached, bit 11 reserved.
// (R03) Status bit 12 is mode specific, 13 mode error, 14 motion end, 15 reference valid.
// (R04) A preset write sets encoder position; singleturn range is 0 to max per rev minus one.
// (R05) Multiturn preset range is 0 to 4096 times max per rev, minus one.
// (R06) Max user position per revolution defaults to 16384.
// (R07) The master sets any direction reversal before writing the preset.
// (R08) A new preset only takes effect at the next controller switch-on.
// (R09) The master waits at least one second after a preset write before switching off; the master model waits only 8 clock cycles.
// (R10) Applying the preset also shifts the virtual and simulated index pulses.
// (R11) Bad realtime data gives a warning for selector 0, a quick stop for 1; default 0.
// (R12) Autosave codes 0..5 mean off, 1, 5, 15, 30 and 60 minutes; default 0.
// (R13) With replacement enabled and autosave on, configuration is stored periodically.
// (R14) With a device name set and replacement enabled, configuration is fetched.
// (R15) Reserved status bit 11 always reads zero.
module drive_status_fieldbus_params
    import drive_params_pkg::*;
#(
    parameter int MAX_POS_PER_REV = MAX_POS_PER_REV_DEFAULT,
    parameter logic [31:0] MINUTE_CYCLES = MINUTE_CYCLES_DEFAULT
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire param_req_t param_req_in,
    output param_rsp_t param_rsp_out,
    input wire drive_flags_t drive_flags_in,
    input wire logic encoder_multiturn_in,
    input wire logic controller_on_in,
    input wire logic rt_data_error_in,
    input wire logic device_name_set_in,
    output logic [15:0] status_word_out,
    output logic [31:0] encoder_position_out,
    output logic encoder_load_out,
    output logic index_shift_out,
    output logic preset_pending_out,
    output logic rt_warning_out,
    output logic quick_stop_out,
    output logic config_fetch_out,
    output logic config_store_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Limits
    localparam logic [63:0] SINGLE_LIMIT = 64'(MAX_POS_PER_REV);
    localparam logic [63:0] MULTI_LIMIT = 64'(MAX_POS_PER_REV) * 64'(MULTITURN_FACTOR);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] status_reg;
    logic [31:0] preset_reg;
    logic preset_pending_reg;
    logic [15:0] behaviour_reg;
    logic [15:0] repl_enable_reg;
    logic [15:0] autosave_reg;
    logic controller_on_prev_reg;
    logic fetch_armed_prev_reg;
    logic minute_tick;
    logic store_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    logic wr_req;
    logic rd_req;
    logic preset_in_range;
    logic preset_wr_ok;
    logic behaviour_wr_ok;
    logic repl_wr_ok;
    logic autosave_wr_ok;
    logic fetch_armed;
    logic switch_on_edge;
    param_rsp_t rsp_next;

    assign wr_req = param_req_in.valid && param_req_in.write;
    assign rd_req = param_req_in.valid && !param_req_in.write;
    assign fetch_armed = (repl_enable_reg == REPLACEMENT_ON) && device_name_set_in;
    assign switch_on_edge = controller_on_in && !controller_on_prev_reg;

    // (R04) Preset range check
    always_comb begin
        preset_in_range = 1'b0;
        if (!param_req_in.wdata[31]) begin
            if (encoder_multiturn_in) begin
                // (R05) Multiturn limit
                preset_in_range = 64'(param_req_in.wdata) < MULTI_LIMIT;
            end else begin
                // (R06) Singleturn limit
                preset_in_range = 64'(param_req_in.wdata) < SINGLE_LIMIT;
            end
        end
    end

    assign preset_wr_ok = wr_req && param_req_in.addr == ADDR_ENCODER_PRESET && preset_in_range;
    assign behaviour_wr_ok = wr_req && param_req_in.addr == ADDR_ERROR_BEHAVIOUR
        && param_req_in.wdata <= 32'(BEHAVIOUR_QUICK_STOP);
    assign repl_wr_ok = wr_req && param_req_in.addr == ADDR_REPLACEMENT_ENABLE
        && param_req_in.wdata <= 32'(REPLACEMENT_ON);
    // (R12) Autosave code range
    assign autosave_wr_ok = wr_req && param_req_in.addr == ADDR_AUTOSAVE_INTERVAL
        && param_req_in.wdata <= 32'(AUTOSAVE_MAX_CODE);

    // Response word
    always_comb begin
        rsp_next.done = param_req_in.valid;
        rsp_next.refused = 1'b0;
        rsp_next.rdata = 32'h0000_0000;
        if (rd_req) begin
            case (param_req_in.addr)
                ADDR_ENCODER_PRESET: rsp_next.rdata = preset_reg;
                ADDR_ERROR_BEHAVIOUR: rsp_next.rdata = {16'h0000, behaviour_reg};
                ADDR_REPLACEMENT_ENABLE: rsp_next.rdata = {16'h0000, repl_enable_reg};
                ADDR_AUTOSAVE_INTERVAL: rsp_next.rdata = {16'h0000, autosave_reg};
                ADDR_STATUS_WORD: rsp_next.rdata = {16'h0000, status_reg};
                default: rsp_next.refused = 1'b1;
            endcase
        end else if (wr_req) begin
            rsp_next.refused = !(preset_wr_ok || behaviour_wr_ok || repl_wr_ok
                || autosave_wr_ok);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            param_rsp_out <= '0;
        end else if (ce_in) begin
            param_rsp_out <= rsp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word
    // (R02) (R03) (R15) Bit packing
    // (R01) Status capture
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_reg <= STATUS_RESET;
            status_word_out <= STATUS_RESET;
        end else if (ce_in) begin
            status_reg <= pack_status(drive_flags_in);
            status_word_out <= pack_status(drive_flags_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoder preset
    // (R08) Deferred apply
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            preset_reg <= PRESET_RESET;
            preset_pending_reg <= 1'b0;
            controller_on_prev_reg <= 1'b0;
            encoder_load_out <= 1'b0;
            index_shift_out <= 1'b0;
            encoder_position_out <= PRESET_RESET;
            preset_pending_out <= 1'b0;
        end else if (ce_in) begin
            controller_on_prev_reg <= controller_on_in;
            encoder_load_out <= 1'b0;
            index_shift_out <= 1'b0;
            if (switch_on_edge && preset_pending_reg) begin
                encoder_load_out <= 1'b1;
                // (R10) Index pulse shift
                index_shift_out <= 1'b1;
                encoder_position_out <= preset_reg;
            end
            if (preset_wr_ok) begin
                preset_reg <= param_req_in.wdata;
                preset_pending_reg <= 1'b1;
                preset_pending_out <= 1'b1;
            end else if (switch_on_edge) begin
                preset_pending_reg <= 1'b0;
                preset_pending_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Realtime data error reaction
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            behaviour_reg <= ERROR_BEHAVIOUR_RESET;
        end else if (ce_in && behaviour_wr_ok) begin
            behaviour_reg <= param_req_in.wdata[15:0];
        end
    end

    // (R11) Warning or quick stop
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rt_warning_out <= 1'b0;
            quick_stop_out <= 1'b0;
        end else if (ce_in) begin
            rt_warning_out <= rt_data_error_in && behaviour_reg == BEHAVIOUR_WARNING;
            quick_stop_out <= rt_data_error_in && behaviour_reg == BEHAVIOUR_QUICK_STOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Device replacement
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            repl_enable_reg <= REPLACEMENT_ENABLE_RESET;
            autosave_reg <= AUTOSAVE_RESET;
        end else if (ce_in) begin
            if (repl_wr_ok) begin
                repl_enable_reg <= param_req_in.wdata[15:0];
            end
            if (autosave_wr_ok) begin
                autosave_reg <= param_req_in.wdata[15:0];
            end
        end
    end

    // (R14) Fetch on enable with name
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fetch_armed_prev_reg <= 1'b0;
            config_fetch_out <= 1'b0;
            config_store_out <= 1'b0;
        end else if (ce_in) begin
            fetch_armed_prev_reg <= fetch_armed;
            config_fetch_out <= fetch_armed && !fetch_armed_prev_reg;
            config_store_out <= store_pulse;
        end
    end

    minute_tick_gen #(
        .CYCLES(MINUTE_CYCLES)
    ) u_minute_tick (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .tick_out(minute_tick)
    );

    // (R13) Autosave gated by enable
    autosave_scheduler u_autosave (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .minute_tick_in(minute_tick),
        .enable_in(repl_enable_reg == REPLACEMENT_ON),
        .interval_code_in(autosave_reg),
        .store_out(store_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_status_state_bits: assert property (ce_in |=> // (R01)
        status_reg[6:5] == $past(drive_flags_in.state_code[5:4])
        && status_reg[STAT_HALT_BIT] == $past(drive_flags_in.halt_active))
        else $error("status state or halt bits wrong");
    a_status_low_bits: assert property (ce_in |=> // (R01)
        status_reg[3:0] == $past(drive_flags_in.state_code[3:0])
        && status_reg[STAT_VOLTAGE_BIT] == $past(drive_flags_in.voltage_enabled)
        && status_reg[STAT_WARNING_BIT] == $past(drive_flags_in.warning))
        else $error("status state, voltage or warning bit wrong");
    a_status_target: assert property (ce_in |=> // (R02)
        status_reg[STAT_TARGET_BIT] == $past(drive_flags_in.target_reached)
        && status_reg[STAT_REMOTE_BIT] == $past(drive_flags_in.remote))
        else $error("status remote or target bit wrong");
    a_status_ref_ok: assert property (ce_in |=> // (R03)
        status_reg[STAT_REF_OK_BIT] == $past(drive_flags_in.ref_valid)
        && status_reg[STAT_MODE_ERR_BIT] == $past(drive_flags_in.mode_error))
        else $error("status ref or mode error bit wrong");
    a_status_mode_bits: assert property (ce_in |=> // (R03)
        status_reg[STAT_MODE_SPEC_BIT] == $past(drive_flags_in.mode_specific)
        && status_reg[STAT_MOTION_END_BIT] == $past(drive_flags_in.motion_end))
        else $error("status mode or motion end bit wrong");
    a_reserved_zero: assert property ( // (R15)
        status_reg[STAT_RESERVED_BIT] == 1'b0 && status_word_out[STAT_RESERVED_BIT] == 1'b0)
        else $error("reserved status bit set");
    a_preset_single_range: assert property (ce_in && wr_req // (R04)
        && param_req_in.addr == ADDR_ENCODER_PRESET && !encoder_multiturn_in
        && param_req_in.wdata == 32'(SINGLE_LIMIT) |=> param_rsp_out.refused)
        else $error("singleturn preset at limit accepted");
    a_preset_multi_range: assert property (ce_in && wr_req // (R05)
        && param_req_in.addr == ADDR_ENCODER_PRESET && encoder_multiturn_in
        && param_req_in.wdata == 32'(MULTI_LIMIT - 64'd1)
        |=> !param_rsp_out.refused && preset_pending_reg)
        else $error("multiturn preset below limit refused");
    a_multi_limit_refused: assert property (ce_in && wr_req // (R05)
        && param_req_in.addr == ADDR_ENCODER_PRESET && encoder_multiturn_in
        && param_req_in.wdata == 32'(MULTI_LIMIT) |=> param_rsp_out.refused)
        else $error("multiturn preset at limit accepted");
    a_preset_default_scale: assert property ( // (R06)
        ce_in && preset_wr_ok && !encoder_multiturn_in
        |-> param_req_in.wdata < 32'(MAX_POS_PER_REV))
        else $error("preset accepted beyond one revolution");
    a_preset_deferred: assert property (encoder_load_out // (R08)
        |-> $past(controller_on_in) && !$past(controller_on_prev_reg)
        && $past(preset_pending_reg))
        else $error("preset applied without switch-on");
    a_preset_held: assert property (ce_in && !switch_on_edge // (R08)
        |=> $stable(encoder_position_out))
        else $error("preset applied before switch-on");
    a_index_follows_load: assert property (ce_in && switch_on_edge // (R10)
        && preset_pending_reg |=> encoder_load_out && index_shift_out
        ##1 (!index_shift_out || !ce_in))
        else $error("index shift not with preset load");
    a_error_reaction: assert property (ce_in && rt_data_error_in // (R11)
        && behaviour_reg == BEHAVIOUR_QUICK_STOP |=> quick_stop_out && !rt_warning_out)
        else $error("quick stop not raised");
    a_warning_reaction: assert property (ce_in && rt_data_error_in // (R11)
        && behaviour_reg == BEHAVIOUR_WARNING |=> rt_warning_out && !quick_stop_out)
        else $error("warning not raised");
    a_fetch_on_arm: assert property (ce_in && fetch_armed && !fetch_armed_prev_reg // (R14)
        |=> config_fetch_out)
        else $error("configuration fetch missing");
    a_fetch_needs_name: assert property (config_fetch_out // (R14)
        |-> $past(device_name_set_in) && $past(repl_enable_reg) == REPLACEMENT_ON)
        else $error("configuration fetch without name or enable");

endmodule
`default_nettype wire

// ---- drive_status_fieldbus_params_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module drive_status_fieldbus_params_tb_top
    import drive_params_pkg::*;
;
    localparam logic [31:0] MIN_CYC = 32'h0000_000A;
    logic clk_in, reset_n_in, ce_in, multi, ctl_on, rt_err, name_set;
    param_req_t req;
    param_rsp_t rsp;
    drive_flags_t flags;
    logic [15:0] status_word_out;
    logic [31:0] enc_pos;
    logic enc_load, idx_shift, pending, rt_warn, qstop, fetch, store;
    logic [31:0] mdl [int];
    int n_fail = 0;
    int n_checks = 0;
    int mins [6] = '{0, 1, 5, 15, 30, 60};
    int n, g;

    always #10 clk_in = ~clk_in;

    drive_status_fieldbus_params #(.MINUTE_CYCLES(MIN_CYC)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .param_req_in(req), .param_rsp_out(rsp), .drive_flags_in(flags),
        .encoder_multiturn_in(multi), .controller_on_in(ctl_on),
        .rt_data_error_in(rt_err), .device_name_set_in(name_set),
        .status_word_out(status_word_out), .encoder_position_out(enc_pos),
        .encoder_load_out(enc_load), .index_shift_out(idx_shift),
        .preset_pending_out(pending), .rt_warning_out(rt_warn), .quick_stop_out(qstop),
        .config_fetch_out(fetch), .config_store_out(store));

    fieldbus_master_model u_master (.clk_in(clk_in), .param_rsp_in(rsp), .param_req_out(req));

    ////////////////////////////////////////////////////////////////////////////
    // Reference model
    function automatic logic [15:0] stat(input drive_flags_t f);
        return {f.ref_valid, f.motion_end, f.mode_error, f.mode_specific, 1'b0,
            f.target_reached, f.remote, f.halt_active, f.warning, f.state_code[5:4],
            f.voltage_enabled, f.state_code[3:0]};
    endfunction

    function automatic logic bad(input logic wr, input int a, input logic [31:0] v);
        longint lim;
        lim = multi ? longint'(MAX_POS_PER_REV_DEFAULT) * 4096 : MAX_POS_PER_REV_DEFAULT;
        if (!mdl.exists(a)) return 1'b1;
        if (!wr) return 1'b0;
        case (a)
            'h052C: return longint'(v) >= lim;
            'h1B04: return 1'b1;
            'h190C, 'h1A28: return v > 1;
            default: return v > 5;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] v);
        param_rsp_t r;
        logic exp_ref;
        exp_ref = bad(wr, a, v);
        u_master.xfer(wr, a, v, r);
        if (wr && !exp_ref) mdl[a] = v;
        check("done", r.done, 1'b1);
        check("refused", r.refused, exp_ref);
        if (!wr && !exp_ref) check("rdata", r.rdata, mdl[a]);
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        n_fail++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(93));
        clk_in = 0;
        reset_n_in = 0;
        ce_in = 1;
        flags = '0;
        {multi, ctl_on, rt_err, name_set} = 4'h0;
        mdl['h052C] = 0;
        mdl['h190C] = 0;
        mdl['h1A28] = 0;
        mdl['h1A2A] = 0;
        mdl['h1B04] = 0;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) reset_n_in = 1;
        foreach (mdl[a]) acc(1'b0, a[15:0], 32'h0);
        acc(1'b0, 16'h1234, 32'h0);
        acc(1'b1, 16'h1B04, 32'h1);
        repeat (8) begin
            @(negedge clk_in) flags = 15'($urandom);
            mdl['h1B04] = 32'(stat(flags));
            @(negedge clk_in);
            check("status", status_word_out, stat(flags));
            acc(1'b0, 16'h1B04, 32'h0);
        end
        // Clock enable low freezes status
        @(negedge clk_in) {ce_in, flags} = {1'b0, ~flags};
        @(negedge clk_in) ce_in = 1'b1;
        check("frozen", status_word_out, mdl['h1B04]);
        foreach (mins[i]) begin
            multi = i > 2;
            acc(1'b1, 16'h052C, i == 0 ? 32'h3FFF : i == 1 ? 32'h4000 : i == 2 ? 32'hFFFF_FFFF :
                i == 3 ? 32'h03FF_FFFF : i == 4 ? 32'h0400_0000 : 32'h5);
            acc(1'b0, 16'h052C, 32'h0);
        end
        check("pending", pending, 1'b1);
        check("position", enc_pos, 32'h0);
        @(negedge clk_in) ctl_on = 1;
        @(negedge clk_in);
        check("load", {enc_load, idx_shift, pending}, 3'h6);
        check("position", enc_pos, 32'h5);
        @(negedge clk_in);
        check("load", {enc_load, idx_shift}, 2'h0);
        u_master.settle();
        @(negedge clk_in) ctl_on = 0;
        for (int b = 0; b < 3; b++) begin
            acc(1'b1, 16'h190C, b);
            @(negedge clk_in) rt_err = 1;
            @(negedge clk_in) rt_err = 0;
            check("rt", {rt_warn, qstop}, mdl['h190C] ? 2'h1 : 2'h2);
        end
        for (int c = 0; c < 7; c++) acc(1'b1, 16'h1A2A, c);
        name_set = 1;
        acc(1'b1, 16'h1A28, 32'h1);
        n = 0;
        while (fetch !== 1'b1 && n < 4) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("fetch", fetch, 1'b1);
        for (int c = 1; c < 3; c++) begin
            acc(1'b1, 16'h1A2A, c);
            n = 0;
            while (store !== 1'b1 && n < 2000) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            g = 0;
            do begin
                @(posedge clk_in);
                #1;
                g++;
            end while (store !== 1'b1 && g < 2000);
            check("period", g, mins[c] * MIN_CYC);
        end
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- fieldbus_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model
    import drive_params_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8
) (
    input wire logic clk_in,
    input wire param_rsp_t param_rsp_in,
    output param_req_t param_req_out
);
    initial begin
        param_req_out = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // No reversal used
    // One request for one cycle, answer taken while it stands
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd,
            output param_rsp_t rsp);
        @(negedge clk_in);
        param_req_out = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
        @(negedge clk_in);
        rsp = param_rsp_in;
        param_req_out = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Wait before switch-off
    task automatic settle();
        repeat (SETTLE_CYCLES) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ---- minute_tick_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module minute_tick_gen
    import drive_params_pkg::*;
#(
    parameter logic [31:0] CYCLES = MINUTE_CYCLES_DEFAULT
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    output logic tick_out
);

    logic [31:0] count_reg;

    // Free-running minute divider
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            if (count_reg == CYCLES - 32'h0000_0001) begin
                count_reg <= 32'h0000_0000;
                tick_out <= 1'b1;
            end else begin
                count_reg <= count_reg + 32'h0000_0001;
                tick_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire
